// >>> hw/tmw_timer8_consts.vh
// tmw_timer8_consts.vh: register map, field positions, reset values and
// mode codes of the eight-bit waveform timer.
// assumes byte addressing on a 32-bit Avalon-MM slave; registers sit in bits 7:0, except the status active compare copy in 15:8.
`ifndef TMW_TIMER8_CONSTS_VH
`define TMW_TIMER8_CONSTS_VH

// register byte addresses
`define TMW_ADDR_CTRL      8'h00
`define TMW_ADDR_COUNT     8'h04
`define TMW_ADDR_COMPARE   8'h08
`define TMW_ADDR_FLAGS     8'h0C
`define TMW_ADDR_PORT      8'h10
`define TMW_ADDR_STATUS    8'h14

// control register fields
`define TMW_CTRL_WAVE_LO   0
`define TMW_CTRL_WAVE_HI   1
`define TMW_CTRL_COM_LO    2
`define TMW_CTRL_COM_HI    3
`define TMW_CTRL_FORCE     7

// flag register fields (write one to clear)
`define TMW_FLAG_OVERFLOW  0
`define TMW_FLAG_COMPARE   1

// port register fields
`define TMW_PORT_VALUE     0
`define TMW_PORT_DIR       1

// status register fields
`define TMW_STAT_STATE     0
`define TMW_STAT_DRIVEN    1
`define TMW_STAT_BLOCK     2
`define TMW_STAT_ACT_LO    8
`define TMW_STAT_ACT_HI    15

// waveform_mode_field codes
`define TMW_WAVE_NORMAL    2'h0
`define TMW_WAVE_PHASE     2'h1
`define TMW_WAVE_CLEAR     2'h2
`define TMW_WAVE_FAST      2'h3

// compare_output_mode codes
`define TMW_COM_OFF        2'h0
`define TMW_COM_TOGGLE     2'h1
`define TMW_COM_CLEAR      2'h2
`define TMW_COM_SET        2'h3

// counter landmarks and reset values
`define TMW_BOTTOM         8'h00
`define TMW_MAX            8'hFF
`define TMW_PRE_MAX        8'hFE
`define TMW_ONE            8'h01
`define TMW_RST_BYTE       8'h00
`define TMW_RST_MODE       2'h0
`define TMW_RST_WORD       32'h0000_0000

`endif

// >>> hw/tmw_cmp_out.v
// tmw_cmp_out.v: compare output unit; holds compare_output_state and
// decides what the pin shows.
// assumes match, bottom and force inputs are single-cycle pulses on CLK_SYS.
`timescale 1ns/1ns
`include "tmw_timer8_consts.vh"

module tmw_cmp_out (
    input  wire       clk,
    input  wire       reset,
    input  wire [1:0] wave_mode,
    input  wire [1:0] com,
    input  wire       match_hit,
    input  wire       bottom_hit,
    input  wire       force_hit,
    input  wire [1:0] force_com,
    input  wire       port_value,
    input  wire       direction,
    output reg        state,
    output wire       pin_out,
    output wire       pin_oe
);

    reg       next_state;
    wire      override;
    wire      fast;

    assign fast     = (wave_mode == `TMW_WAVE_FAST);
    assign override = |com; // mode field alone decides the override

    // next output state: fast pwm bottom action is last so it wins a
    // same-tick match, which gives the steady level at compare = max
    always @* begin
        next_state = state;
        if (force_hit && !fast) begin // force acts at once, non-pwm only
            case (force_com) // same action as a real match
                `TMW_COM_TOGGLE: next_state = ~state;
                `TMW_COM_CLEAR:  next_state = 1'b0;
                `TMW_COM_SET:    next_state = 1'b1;
                default:         next_state = state;
            endcase
        end else if (match_hit) begin
            case (com) // mode zero leaves the state alone
                `TMW_COM_TOGGLE: next_state = fast ? state : ~state;
                `TMW_COM_CLEAR:  next_state = 1'b0;
                `TMW_COM_SET:    next_state = 1'b1;
                default:         next_state = state;
            endcase
        end
        if (bottom_hit && fast) begin
            case (com) // opposite action at bottom
                `TMW_COM_CLEAR: next_state = 1'b1;
                `TMW_COM_SET:   next_state = 1'b0;
                default:        next_state = next_state;
            endcase
        end
    end

    // state register, cleared by system reset only
    always @(posedge clk) begin
        if (reset) begin
            state <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // pin mux: direction still gates the driver
    assign pin_oe  = direction;
    assign pin_out = direction & (override ? state : port_value);

endmodule

// >>> hw/tmw_timer8.v
// tmw_timer8.v: eight-bit timer/counter with compare output, normal,
// clear-on-match and fast pwm modes, behind an Avalon-MM slave.
// assumes TIMER_TICK is the single-cycle timer clock enable from the prescaler,
// synchronous to CLK_SYS; the bus master holds each request until waitrequest drops.
`timescale 1ns/1ns
`include "tmw_timer8_consts.vh"

module tmw_timer8 (
    input  wire        CLK_SYS,
    input  wire        RESET,
    input  wire        TIMER_TICK,
    input  wire [7:0]  AVS_ADDRESS,
    input  wire        AVS_READ,
    input  wire        AVS_WRITE,
    input  wire [31:0] AVS_WRITEDATA,
    input  wire [3:0]  AVS_BYTEENABLE,
    output reg  [31:0] AVS_READDATA,
    output wire        AVS_WAITREQUEST,
    output wire        PIN_OUT,
    output wire        PIN_OE,
    output wire        OVERFLOW_FLAG,
    output wire        COMPARE_FLAG
);

    // software-visible state
    reg  [1:0]  wave_mode;
    reg  [1:0]  com;
    reg  [7:0]  count;
    reg  [7:0]  cmp_buf;
    reg  [7:0]  cmp_active;
    reg         ovf_flag;
    reg         cmp_flag;
    reg         port_value;
    reg         direction;

    // internal state
    reg         block_match;
    reg         bus_ack;

    // next values
    reg  [7:0]  next_count;
    reg         next_ovf_flag;
    reg         next_cmp_flag;
    reg  [7:0]  next_cmp_active;
    reg         next_block;
    reg  [31:0] next_readdata;

    // decoded events
    reg         match_hit;
    reg         bottom_hit;
    reg         ovf_hit;
    reg         top_load;

    wire        bus_req;
    wire        wr_take;
    wire        rd_take;
    wire        lane0;
    wire        wr_ctrl;
    wire        wr_count;
    wire        wr_compare;
    wire        wr_flags;
    wire        wr_port;
    wire        force_hit;
    wire        is_eq;
    wire        fast;
    wire        state;

    // bus handshake: every access takes exactly one wait cycle, which
    // lets read data come from a flop without a combinational path
    assign bus_req         = AVS_READ | AVS_WRITE;
    assign AVS_WAITREQUEST = bus_req & ~bus_ack;
    assign wr_take         = AVS_WRITE & bus_ack;
    assign rd_take         = AVS_READ & ~bus_ack;
    assign lane0           = AVS_BYTEENABLE[0];

    // write decode, only the low byte lane carries register bits
    assign wr_ctrl    = wr_take & lane0 & (AVS_ADDRESS == `TMW_ADDR_CTRL);
    assign wr_count   = wr_take & lane0 & (AVS_ADDRESS == `TMW_ADDR_COUNT);
    assign wr_compare = wr_take & lane0 & (AVS_ADDRESS == `TMW_ADDR_COMPARE);
    assign wr_flags   = wr_take & lane0 & (AVS_ADDRESS == `TMW_ADDR_FLAGS);
    assign wr_port    = wr_take & lane0 & (AVS_ADDRESS == `TMW_ADDR_PORT);

    // force is a strobe carried by the control write itself
    assign force_hit = wr_ctrl & AVS_WRITEDATA[`TMW_CTRL_FORCE];

    assign is_eq = (count == cmp_active);
    assign fast  = (wave_mode == `TMW_WAVE_FAST);

    assign OVERFLOW_FLAG = ovf_flag;
    assign COMPARE_FLAG  = cmp_flag;

    // counter sequence: chosen by waveform mode only, output mode is
    // never looked at here
    always @* begin
        next_count = count;
        ovf_hit    = 1'b0;
        bottom_hit = 1'b0;
        top_load   = 1'b0;
        // the match is seen on the tick that closes the matched cycle,
        // and a counter write masks the tick that follows it
        match_hit  = TIMER_TICK & is_eq & ~block_match
                     & (wave_mode != `TMW_WAVE_PHASE);
        if (TIMER_TICK) begin
            case (wave_mode)
                `TMW_WAVE_NORMAL: begin
                    next_count = count + `TMW_ONE; // wraps through max
                    ovf_hit    = (count == `TMW_MAX);
                end
                `TMW_WAVE_CLEAR: begin
                    // a compare below the count is simply missed until the
                    // wrap, since the compare value is unbuffered here
                    if (match_hit) begin
                        next_count = `TMW_BOTTOM;
                    end else begin
                        next_count = count + `TMW_ONE;
                    end
                    ovf_hit = (count == `TMW_MAX);
                end
                `TMW_WAVE_FAST: begin
                    next_count = count + `TMW_ONE; // 256 states
                    ovf_hit    = (count == `TMW_PRE_MAX); // on reaching max
                    bottom_hit = (count == `TMW_MAX); // max to bottom
                    top_load   = (count == `TMW_MAX);
                end
                default: begin
                    next_count = count; // phase-correct mode is not built: hold
                end
            endcase
        end
        if (wr_count) begin
            next_count = AVS_WRITEDATA[7:0]; // write beats any count or clear
        end
    end

    // match blocking: armed by a counter write, dropped by the next tick
    always @* begin
        next_block = block_match;
        if (TIMER_TICK) begin
            next_block = 1'b0;
        end
        if (wr_count) begin
            next_block = 1'b1; // even with the timer stopped
        end
    end

    // active compare copy: direct in non-pwm modes, loaded at top in fast pwm
    always @* begin
        next_cmp_active = cmp_active;
        if (fast) begin
            if (top_load) begin
                next_cmp_active = cmp_buf;
            end
        end else if (wr_compare) begin
            next_cmp_active = AVS_WRITEDATA[7:0];
        end else begin
            next_cmp_active = cmp_buf;
        end
    end

    // flags: hardware set wins over a write-one clear in the same cycle;
    // force never sets the compare flag
    always @* begin
        next_ovf_flag = ovf_flag;
        next_cmp_flag = cmp_flag;
        if (wr_flags && AVS_WRITEDATA[`TMW_FLAG_OVERFLOW]) begin
            next_ovf_flag = 1'b0;
        end
        if (wr_flags && AVS_WRITEDATA[`TMW_FLAG_COMPARE]) begin
            next_cmp_flag = 1'b0;
        end
        if (ovf_hit) begin
            next_ovf_flag = 1'b1; // never cleared by hardware
        end
        if (match_hit) begin
            next_cmp_flag = 1'b1;
        end
    end

    // read mux, captured in the wait cycle; unmapped addresses read zero
    always @* begin
        next_readdata = `TMW_RST_WORD;
        case (AVS_ADDRESS)
            `TMW_ADDR_CTRL: begin
                next_readdata[`TMW_CTRL_WAVE_HI:`TMW_CTRL_WAVE_LO] = wave_mode;
                next_readdata[`TMW_CTRL_COM_HI:`TMW_CTRL_COM_LO]   = com;
            end
            `TMW_ADDR_COUNT: begin
                next_readdata[7:0] = count;
            end
            `TMW_ADDR_COMPARE: begin
                next_readdata[7:0] = cmp_buf;
            end
            `TMW_ADDR_FLAGS: begin
                next_readdata[`TMW_FLAG_OVERFLOW] = ovf_flag;
                next_readdata[`TMW_FLAG_COMPARE]  = cmp_flag;
            end
            `TMW_ADDR_PORT: begin
                next_readdata[`TMW_PORT_VALUE] = port_value;
                next_readdata[`TMW_PORT_DIR]   = direction;
            end
            `TMW_ADDR_STATUS: begin
                next_readdata[`TMW_STAT_STATE]  = state;
                next_readdata[`TMW_STAT_DRIVEN] = PIN_OE;
                next_readdata[`TMW_STAT_BLOCK]  = block_match;
                next_readdata[`TMW_STAT_ACT_HI:`TMW_STAT_ACT_LO] = cmp_active;
            end
            default: begin
                next_readdata = `TMW_RST_WORD;
            end
        endcase
    end

    // bus side registers
    always @(posedge CLK_SYS) begin
        if (RESET) begin
            bus_ack      <= 1'b0;
            AVS_READDATA <= `TMW_RST_WORD;
        end else begin
            bus_ack <= bus_req & ~bus_ack;
            if (rd_take) begin
                AVS_READDATA <= next_readdata;
            end
        end
    end

    // configuration registers; a new output mode simply waits for the
    // next match, it is not double buffered with the compare value
    always @(posedge CLK_SYS) begin
        if (RESET) begin
            wave_mode  <= `TMW_RST_MODE;
            com        <= `TMW_RST_MODE;
            cmp_buf    <= `TMW_RST_BYTE;
            port_value <= 1'b0;
            direction  <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                wave_mode <= AVS_WRITEDATA[`TMW_CTRL_WAVE_HI:`TMW_CTRL_WAVE_LO];
                com       <= AVS_WRITEDATA[`TMW_CTRL_COM_HI:`TMW_CTRL_COM_LO];
            end
            if (wr_compare) begin
                cmp_buf <= AVS_WRITEDATA[7:0];
            end
            if (wr_port) begin
                port_value <= AVS_WRITEDATA[`TMW_PORT_VALUE];
                direction  <= AVS_WRITEDATA[`TMW_PORT_DIR];
            end
        end
    end

    // counting state
    always @(posedge CLK_SYS) begin
        if (RESET) begin
            count       <= `TMW_RST_BYTE;
            cmp_active  <= `TMW_RST_BYTE;
            block_match <= 1'b0;
            ovf_flag    <= 1'b0;
            cmp_flag    <= 1'b0;
        end else begin
            count       <= next_count;
            cmp_active  <= next_cmp_active;
            block_match <= next_block;
            ovf_flag    <= next_ovf_flag;
            cmp_flag    <= next_cmp_flag;
        end
    end

    // output unit; force uses the output mode carried by the same write
    tmw_cmp_out u_cmp_out (
        .clk        (CLK_SYS),
        .reset      (RESET),
        .wave_mode  (wave_mode),
        .com        (com),
        .match_hit  (match_hit),
        .bottom_hit (bottom_hit),
        .force_hit  (force_hit),
        .force_com  (AVS_WRITEDATA[`TMW_CTRL_COM_HI:`TMW_CTRL_COM_LO]),
        .port_value (port_value),
        .direction  (direction),
        .state      (state),
        .pin_out    (PIN_OUT),
        .pin_oe     (PIN_OE)
    );

endmodule

// >>> bench/tmw_timer8_asserts.sv
// tmw_timer8_asserts.sv: port-level checker for the eight-bit waveform timer.
// assumes it is bound to tmw_timer8 and sees only its top-level ports.
`timescale 1ns/1ns
`include "tmw_timer8_consts.vh"

module tmw_timer8_asserts (
    input wire        CLK_SYS,
    input wire        RESET,
    input wire        TIMER_TICK,
    input wire [7:0]  AVS_ADDRESS,
    input wire        AVS_WRITE,
    input wire        AVS_WAITREQUEST,
    input wire        PIN_OUT,
    input wire        PIN_OE,
    input wire        OVERFLOW_FLAG,
    input wire        COMPARE_FLAG
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RESET);

    // a write is taken only at the edge where waitrequest is low
    wire wr_taken = AVS_WRITE && !AVS_WAITREQUEST;

    // pin value and both flags come out of reset cleared
    AST_RESET_CLEAR: assert property ($past(RESET) |-> !PIN_OUT && !OVERFLOW_FLAG && !COMPARE_FLAG)
        else $error("outputs not cleared after reset");
    // undriven pin never shows a stale one
    AST_UNDRIVEN: assert property (!PIN_OE |-> !PIN_OUT)
        else $error("pin value shown while undriven");
    // the drive enable only follows a port register write
    AST_OE_BY_WRITE: assert property ($changed(PIN_OE) |-> $past(wr_taken && AVS_ADDRESS == `TMW_ADDR_PORT))
        else $error("pin enable changed without port write");
    // pin moves only on a timer clock or a register write
    AST_PIN_CAUSE: assert property ($changed(PIN_OUT) |-> $past(TIMER_TICK || wr_taken))
        else $error("pin changed without tick or write");
    // compare flag sets only on a timer clock
    AST_CMP_TICK: assert property ($rose(COMPARE_FLAG) |-> $past(TIMER_TICK))
        else $error("compare flag set without tick");
    // overflow flag sets only on a timer clock
    AST_OVF_TICK: assert property ($rose(OVERFLOW_FLAG) |-> $past(TIMER_TICK))
        else $error("overflow flag set without tick");
    // hardware never clears overflow on its own
    AST_OVF_HOLD: assert property ($fell(OVERFLOW_FLAG) |-> $past(wr_taken && AVS_ADDRESS == `TMW_ADDR_FLAGS))
        else $error("overflow flag cleared without write");
    // compare flag likewise only cleared by software
    AST_CMP_HOLD: assert property ($fell(COMPARE_FLAG) |-> $past(wr_taken && AVS_ADDRESS == `TMW_ADDR_FLAGS))
        else $error("compare flag cleared without write");

    cover property ($rose(COMPARE_FLAG));
    cover property ($rose(OVERFLOW_FLAG));
    cover property (PIN_OE && $changed(PIN_OUT));
endmodule

bind tmw_timer8 tmw_timer8_asserts u_chk (.CLK_SYS(CLK_SYS), .RESET(RESET),
    .TIMER_TICK(TIMER_TICK), .AVS_ADDRESS(AVS_ADDRESS), .AVS_WRITE(AVS_WRITE),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
    .OVERFLOW_FLAG(OVERFLOW_FLAG), .COMPARE_FLAG(COMPARE_FLAG));

// >>> bench/tmw_pin_load.sv
// tmw_pin_load.sv: external load on the compare pin, with a weak pull-down.
// assumes the pin is driven only while its enable is high.
`timescale 1ns/1ns

module tmw_pin_load (
    input  wire pin_out,
    input  wire pin_oe,
    output wire pin_level
);
    // released pin falls to the pull level, never keeps the last value
    assign pin_level = pin_oe ? pin_out : 1'b0;
endmodule

// >>> bench/tmw_timer8_bench.sv
// tmw_timer8_bench.sv: self-checking bench for the eight-bit waveform timer.
// assumes design, checker and pin load are compiled first; timer ticks come from here.
`timescale 1ns/1ns
`include "tmw_timer8_consts.vh"

module tmw_timer8_bench;
    logic        CLK_SYS = 0;
    logic        RESET = 1;
    logic        TIMER_TICK = 0;
    logic [7:0]  AVS_ADDRESS = 8'h00;
    logic        AVS_READ = 0;
    logic        AVS_WRITE = 0;
    logic [31:0] AVS_WRITEDATA = 32'h0000_0000;
    logic [3:0]  AVS_BYTEENABLE = 4'h1;
    wire  [31:0] AVS_READDATA;
    wire         AVS_WAITREQUEST;
    wire         PIN_OUT;
    wire         PIN_OE;
    wire         OVERFLOW_FLAG;
    wire         COMPARE_FLAG;
    wire         pin_level;
    int          bad_count = 0;
    int          samples_checked = 0;
    logic [15:0] rv;

    tmw_timer8 uut (.CLK_SYS(CLK_SYS), .RESET(RESET), .TIMER_TICK(TIMER_TICK),
        .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
        .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
        .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
        .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .OVERFLOW_FLAG(OVERFLOW_FLAG),
        .COMPARE_FLAG(COMPARE_FLAG));
    tmw_pin_load load (.pin_out(PIN_OUT), .pin_oe(PIN_OE), .pin_level(pin_level));

    // 20 MHz system clock
    initial begin
        forever #25 CLK_SYS = ~CLK_SYS;
    end

    task check(input logic [15:0] seen, input logic [15:0] want);
        samples_checked++;
        if (seen !== want) begin
            bad_count++;
            $display("FAIL %0t seen %h want %h", $time, seen, want);
        end
    endtask

    // request held until the rising edge that sees waitrequest low; data taken there
    task bus(input logic rw, input logic [7:0] a, input logic [7:0] d);
        AVS_ADDRESS   <= a;
        AVS_WRITEDATA <= {24'h00_0000, d};
        AVS_WRITE     <= rw;
        AVS_READ      <= !rw;
        do @(posedge CLK_SYS); while (AVS_WAITREQUEST !== 1'b0);
        rv = AVS_READDATA[15:0];
        AVS_WRITE <= 0;
        AVS_READ  <= 0;
        // one idle edge so the next request never reassigns in this step
        @(posedge CLK_SYS);
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask

    task rdc(input logic [7:0] a, input logic [15:0] want);
        bus(1'b0, a, 8'h00);
        check(rv, want);
    endtask

    // enable and level of the loaded pin, looked at mid-cycle
    task pinchk(input logic [15:0] want);
        @(negedge CLK_SYS);
        check({14'h0000, PIN_OE, pin_level}, want);
        @(posedge CLK_SYS);
    endtask

    task tick(input int n);
        repeat (n) begin
            TIMER_TICK <= 1;
            @(posedge CLK_SYS);
            TIMER_TICK <= 0;
            @(posedge CLK_SYS);
        end
    endtask

    task t_reset;
        for (int a = 0; a <= 32; a += 4) begin
            rdc(a[7:0], 16'h0000);
        end
        pinchk(16'h0000);
        $display("test reset done");
    endtask

    task t_normal;
        wr(`TMW_ADDR_COMPARE, 8'h80);
        wr(`TMW_ADDR_COUNT, 8'hFE);
        tick(1);
        rdc(`TMW_ADDR_COUNT, 16'h00FF);
        rdc(`TMW_ADDR_FLAGS, 16'h0000);
        tick(1);
        rdc(`TMW_ADDR_COUNT, 16'h0000);
        rdc(`TMW_ADDR_FLAGS, 16'h0001);
        tick(3);
        rdc(`TMW_ADDR_FLAGS, 16'h0001);
        wr(`TMW_ADDR_FLAGS, 8'h03);
        rdc(`TMW_ADDR_FLAGS, 16'h0000);
        $display("test normal done");
    endtask

    task t_force;
        wr(`TMW_ADDR_PORT, 8'h03);
        pinchk(16'h0003);
        wr(`TMW_ADDR_CTRL, 8'h84);
        bus(1'b0, `TMW_ADDR_STATUS, 8'h00);
        check(rv & 16'hFF01, 16'h8001);
        check({15'h0000, COMPARE_FLAG}, 16'h0000);
        wr(`TMW_ADDR_CTRL, 8'h88);
        pinchk(16'h0002);
        wr(`TMW_ADDR_CTRL, 8'h80);
        pinchk(16'h0003);
        rdc(`TMW_ADDR_COUNT, 16'h0003);
        wr(`TMW_ADDR_PORT, 8'h01);
        pinchk(16'h0000);
        $display("test force done");
    endtask

    task t_ctc;
        wr(`TMW_ADDR_PORT, 8'h02);
        wr(`TMW_ADDR_COMPARE, 8'h03);
        wr(`TMW_ADDR_COUNT, 8'h00);
        wr(`TMW_ADDR_CTRL, 8'h06);
        tick(3);
        pinchk(16'h0002);
        tick(1);
        pinchk(16'h0003);
        rdc(`TMW_ADDR_COUNT, 16'h0000);
        rdc(`TMW_ADDR_FLAGS, 16'h0002);
        wr(`TMW_ADDR_CTRL, 8'h02);
        tick(4);
        bus(1'b0, `TMW_ADDR_STATUS, 8'h00);
        check(rv & 16'h0001, 16'h0001);
        wr(`TMW_ADDR_CTRL, 8'h06);
        tick(4);
        pinchk(16'h0002);
        wr(`TMW_ADDR_FLAGS, 8'h03);
        wr(`TMW_ADDR_COUNT, 8'h03);
        tick(1);
        rdc(`TMW_ADDR_COUNT, 16'h0004);
        rdc(`TMW_ADDR_FLAGS, 16'h0000);
        wr(`TMW_ADDR_COMPARE, 8'h02);
        tick(251);
        rdc(`TMW_ADDR_COUNT, 16'h00FF);
        tick(1);
        rdc(`TMW_ADDR_FLAGS, 16'h0001);
        tick(3);
        rdc(`TMW_ADDR_COUNT, 16'h0000);
        rdc(`TMW_ADDR_FLAGS, 16'h0003);
        $display("test clear-on-match done");
    endtask

    task t_fast;
        wr(`TMW_ADDR_FLAGS, 8'h03);
        wr(`TMW_ADDR_CTRL, 8'h0B);
        wr(`TMW_ADDR_COMPARE, 8'h80);
        wr(`TMW_ADDR_COUNT, 8'hFE);
        tick(1);
        rdc(`TMW_ADDR_FLAGS, 16'h0001);
        tick(1);
        rdc(`TMW_ADDR_COUNT, 16'h0000);
        bus(1'b0, `TMW_ADDR_STATUS, 8'h00);
        check(rv & 16'hFF01, 16'h8001);
        tick(128);
        pinchk(16'h0003);
        tick(1);
        pinchk(16'h0002);
        tick(127);
        pinchk(16'h0003);
        rdc(`TMW_ADDR_COUNT, 16'h0000);
        wr(`TMW_ADDR_COMPARE, 8'hFF);
        wr(`TMW_ADDR_CTRL, 8'h0F);
        tick(256);
        pinchk(16'h0002);
        tick(200);
        pinchk(16'h0002);
        $display("test fast pwm done");
    endtask

    task test_done;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // reset for five cycles, then every scenario in turn
    initial begin
        repeat (5) @(posedge CLK_SYS);
        RESET <= 0;
        @(posedge CLK_SYS);
        t_reset;
        t_normal;
        t_force;
        t_ctc;
        t_fast;
        test_done;
    end

    // the scenarios need about 2200 cycles; a hang ends the run well after that
    initial begin
        repeat (20000) @(posedge CLK_SYS);
        bad_count++;
        test_done;
    end
endmodule
